// File: rtl/clsd_regs.svh
// Encoding constants for the custom load/store decoder
`ifndef CLSD_REGS_SVH
`define CLSD_REGS_SVH
// Instruction field ranges
`define CLSD_F_OPC 6:0
`define CLSD_F_RD 11:7
`define CLSD_F_F3 14:12
`define CLSD_F_RS1 19:15
`define CLSD_F_RS2 24:20
`define CLSD_F_F7 31:25
`define CLSD_F_IMMI 31:20
`define CLSD_SIGN_BIT 31
`define CLSD_IMM_SIGN 11
`define CLSD_IMM_EXT 20
// Sub-fields of funct3 and funct7
`define CLSD_F3_SZ 1:0
`define CLSD_F3_UNS 2
`define CLSD_F7_SZ 1:0
`define CLSD_F7_NOUPD 2
`define CLSD_F7_UNS 3
`define CLSD_F7_ST 4
// Major opcodes
`define CLSD_OPC_LDI 7'h0B
`define CLSD_OPC_MEM 7'h2B
// funct3 values
`define CLSD_F3_B 3'h0
`define CLSD_F3_H 3'h1
`define CLSD_F3_W 3'h2
`define CLSD_F3_RR 3'h3
`define CLSD_F3_BU 3'h4
`define CLSD_F3_HU 3'h5
// funct7 values, function field 011
`define CLSD_F7_LB_PI 7'h00
`define CLSD_F7_LBU_PI 7'h08
`define CLSD_F7_LH_PI 7'h01
`define CLSD_F7_LHU_PI 7'h09
`define CLSD_F7_LW_PI 7'h02
`define CLSD_F7_LB_RR 7'h04
`define CLSD_F7_LBU_RR 7'h0C
`define CLSD_F7_LH_RR 7'h05
`define CLSD_F7_LHU_RR 7'h0D
`define CLSD_F7_LW_RR 7'h06
`define CLSD_F7_SB_PI 7'h10
`define CLSD_F7_SH_PI 7'h11
`define CLSD_F7_SW_PI 7'h12
`define CLSD_F7_SB_RR 7'h14
`define CLSD_F7_SH_RR 7'h15
`define CLSD_F7_SW_RR 7'h16
// Byte enables and reset values
`define CLSD_BE_BYTE 4'h1
`define CLSD_BE_HALF 4'h3
`define CLSD_BE_WORD 4'hF
`define CLSD_ZERO32 32'h0000_0000
`endif

// File: rtl/clsd_pkg.sv
// Types shared by the custom load/store decoder
package clsd_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} clsd_size_type;
  typedef enum logic [1:0] {OFF_IMM, OFF_RS2, OFF_RS3} clsd_off_type;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} clsd_state_type;
  typedef struct packed {
    logic hit;
    logic is_store;
    logic is_elw;
    logic uns;
    logic upd;
    clsd_size_type size;
    clsd_off_type off;
    logic [31:0] imm;
  } clsd_dec_type;
endpackage

// File: rtl/clsd_decoder.sv
// Custom post-increment / register-register load-store and event-load execution unit
`timescale 1ns/100ps
`include "clsd_regs.svh"
module clsd_decoder #(
  parameter bit custom_ext_enable_param = 1'b1,
  parameter bit cluster_ext_enable_param = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Instruction from decode, with register file operands
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] rs1_val_in,
  input wire logic [31:0] rs2_val_in,
  input wire logic [31:0] rs3_val_in,
  output logic instr_ready_out,
  output logic illegal_out,
  // Load-store unit
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [3:0] mem_be_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_gnt_in,
  input wire logic mem_rvalid_in,
  input wire logic [31:0] mem_rdata_in,
  // Register file write ports
  output logic rd_we_out,
  output logic [4:0] rd_addr_out,
  output logic [31:0] rd_wdata_out,
  output logic base_we_out,
  output logic [4:0] base_addr_out,
  output logic [31:0] base_wdata_out,
  // Sleep request after an event load
  output logic sleep_req_out
);

  function automatic clsd_pkg::clsd_dec_type decode(input logic [31:0] ins);
    clsd_pkg::clsd_dec_type d;
    logic [6:0] f7;
    logic [2:0] f3;
    f7 = ins[`CLSD_F_F7];
    f3 = ins[`CLSD_F_F3];
    d.hit = 1'b0;
    d.is_store = 1'b0;
    d.is_elw = 1'b0;
    d.uns = 1'b0;
    d.upd = 1'b1;
    d.size = clsd_pkg::SZ_WORD;
    d.off = clsd_pkg::OFF_IMM;
    d.imm = {{`CLSD_IMM_EXT{ins[`CLSD_SIGN_BIT]}}, ins[`CLSD_F_IMMI]};
    if (ins[`CLSD_F_OPC] == `CLSD_OPC_LDI) begin
      case (f3)
        `CLSD_F3_B, `CLSD_F3_BU, `CLSD_F3_H, `CLSD_F3_HU, `CLSD_F3_W: begin
          d.hit = 1'b1;
          d.size = clsd_pkg::clsd_size_type'(f3[`CLSD_F3_SZ]);
          d.uns = f3[`CLSD_F3_UNS];
        end
        `CLSD_F3_RR: begin
          d.hit = 1'b1;
          d.is_elw = 1'b1;
          d.upd = 1'b0;
        end
        default: d.hit = 1'b0;
      endcase
    end else if (ins[`CLSD_F_OPC] == `CLSD_OPC_MEM && f3 == `CLSD_F3_RR) begin
      case (f7)
        `CLSD_F7_LB_PI, `CLSD_F7_LBU_PI, `CLSD_F7_LH_PI, `CLSD_F7_LHU_PI, `CLSD_F7_LW_PI,
        `CLSD_F7_LB_RR, `CLSD_F7_LBU_RR, `CLSD_F7_LH_RR, `CLSD_F7_LHU_RR, `CLSD_F7_LW_RR,
        `CLSD_F7_SB_PI, `CLSD_F7_SH_PI, `CLSD_F7_SW_PI,
        `CLSD_F7_SB_RR, `CLSD_F7_SH_RR, `CLSD_F7_SW_RR: d.hit = 1'b1;
        default: d.hit = 1'b0;
      endcase
      d.size = clsd_pkg::clsd_size_type'(f7[`CLSD_F7_SZ]);
      d.uns = f7[`CLSD_F7_UNS];
      d.upd = !f7[`CLSD_F7_NOUPD];
      d.is_store = f7[`CLSD_F7_ST];
      d.off = f7[`CLSD_F7_ST] ? clsd_pkg::OFF_RS3 : clsd_pkg::OFF_RS2;
    end else if (ins[`CLSD_F_OPC] == `CLSD_OPC_MEM) begin
      // The hardware-loop group shares this opcode, so only the three store codes hit
      case (f3)
        `CLSD_F3_B, `CLSD_F3_H, `CLSD_F3_W: d.hit = 1'b1;
        default: d.hit = 1'b0;
      endcase
      d.is_store = 1'b1;
      d.size = clsd_pkg::clsd_size_type'(f3[`CLSD_F3_SZ]);
      d.imm = {{`CLSD_IMM_EXT{ins[`CLSD_SIGN_BIT]}}, ins[`CLSD_F_F7], ins[`CLSD_F_RD]};
    end
    return d;
  endfunction

  function automatic logic [3:0] lane_be(input clsd_pkg::clsd_size_type s, input logic [1:0] a);
    logic [3:0] be;
    unique case (s)
      clsd_pkg::SZ_BYTE: be = `CLSD_BE_BYTE << a;
      clsd_pkg::SZ_HALF: be = `CLSD_BE_HALF << a;
      default: be = `CLSD_BE_WORD;
    endcase
    return be;
  endfunction

  function automatic logic [31:0] load_ext(input logic [31:0] w, input logic [1:0] a,
                                           input clsd_pkg::clsd_size_type s, input logic u);
    logic [31:0] sh;
    logic [31:0] r;
    sh = w >> {a, 3'h0};
    unique case (s)
      clsd_pkg::SZ_BYTE: r = u ? {24'h000000, sh[7:0]} : {{24{sh[7]}}, sh[7:0]};
      clsd_pkg::SZ_HALF: r = u ? {16'h0000, sh[15:0]} : {{16{sh[15]}}, sh[15:0]};
      default: r = w;
    endcase
    return r;
  endfunction

  clsd_pkg::clsd_dec_type dec;
  logic accept;
  logic enabled;
  logic [31:0] offset;
  logic [31:0] sum;

  clsd_pkg::clsd_state_type state_r, state_nxt;
  logic ready_r, ready_nxt;
  logic illegal_r, illegal_nxt;
  logic req_r, req_nxt;
  logic we_r, we_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [3:0] be_r, be_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic rd_we_r, rd_we_nxt;
  logic [4:0] rd_addr_r, rd_addr_nxt;
  logic [31:0] rd_wdata_r, rd_wdata_nxt;
  logic base_we_r, base_we_nxt;
  logic [4:0] base_addr_r, base_addr_nxt;
  logic [31:0] base_wdata_r, base_wdata_nxt;
  logic sleep_r, sleep_nxt;
  clsd_pkg::clsd_size_type size_r, size_nxt;
  logic uns_r, uns_nxt;
  logic upd_r, upd_nxt;
  logic elw_r, elw_nxt;

  always_comb begin
    dec = decode(instr_in);
    enabled = dec.is_elw ? cluster_ext_enable_param : custom_ext_enable_param;
    accept = instr_valid_in && ready_r && dec.hit;
    unique case (dec.off)
      clsd_pkg::OFF_RS2: offset = rs2_val_in;
      clsd_pkg::OFF_RS3: offset = rs3_val_in;
      default: offset = dec.imm;
    endcase
    sum = rs1_val_in + offset;
  end

  always_comb begin
    state_nxt = state_r;
    ready_nxt = (state_r == clsd_pkg::ST_IDLE) ? 1'b1 : ready_r;
    illegal_nxt = 1'b0;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    be_nxt = be_r;
    wdata_nxt = wdata_r;
    rd_we_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    rd_wdata_nxt = rd_wdata_r;
    base_we_nxt = 1'b0;
    base_addr_nxt = base_addr_r;
    base_wdata_nxt = base_wdata_r;
    sleep_nxt = 1'b0;
    size_nxt = size_r;
    uns_nxt = uns_r;
    upd_nxt = upd_r;
    elw_nxt = elw_r;
    unique case (state_r)
      clsd_pkg::ST_IDLE: begin
        if (accept && !enabled) begin
          illegal_nxt = 1'b1;
        end else if (accept) begin
          state_nxt = clsd_pkg::ST_REQ;
          ready_nxt = 1'b0;
          req_nxt = 1'b1;
          we_nxt = dec.is_store;
          addr_nxt = dec.upd ? rs1_val_in : sum;
          be_nxt = lane_be(dec.size, addr_nxt[1:0]);
          wdata_nxt = rs2_val_in << {addr_nxt[1:0], 3'h0};
          rd_addr_nxt = instr_in[`CLSD_F_RD];
          base_addr_nxt = instr_in[`CLSD_F_RS1];
          base_wdata_nxt = sum;
          size_nxt = dec.size;
          uns_nxt = dec.uns;
          upd_nxt = dec.upd;
          elw_nxt = dec.is_elw;
        end
      end
      clsd_pkg::ST_REQ: begin
        if (mem_gnt_in) begin
          req_nxt = 1'b0;
          if (we_r) begin
            // Stores are finished once the unit takes them
            state_nxt = clsd_pkg::ST_IDLE;
            ready_nxt = 1'b1;
            base_we_nxt = upd_r && base_addr_r != 5'h00;
          end else begin
            state_nxt = clsd_pkg::ST_WAIT;
          end
        end
      end
      clsd_pkg::ST_WAIT: begin
        if (mem_rvalid_in) begin
          state_nxt = clsd_pkg::ST_IDLE;
          ready_nxt = 1'b1;
          rd_we_nxt = rd_addr_r != 5'h00;
          rd_wdata_nxt = load_ext(mem_rdata_in, addr_r[1:0], size_r, uns_r);
          base_we_nxt = upd_r && base_addr_r != 5'h00;
          sleep_nxt = elw_r;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= clsd_pkg::ST_IDLE;
      ready_r <= 1'b0;
      illegal_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= `CLSD_ZERO32;
      be_r <= 4'h0;
      wdata_r <= `CLSD_ZERO32;
      rd_we_r <= 1'b0;
      rd_addr_r <= 5'h00;
      rd_wdata_r <= `CLSD_ZERO32;
      base_we_r <= 1'b0;
      base_addr_r <= 5'h00;
      base_wdata_r <= `CLSD_ZERO32;
      sleep_r <= 1'b0;
      size_r <= clsd_pkg::SZ_WORD;
      uns_r <= 1'b0;
      upd_r <= 1'b0;
      elw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      illegal_r <= illegal_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      be_r <= be_nxt;
      wdata_r <= wdata_nxt;
      rd_we_r <= rd_we_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_wdata_r <= rd_wdata_nxt;
      base_we_r <= base_we_nxt;
      base_addr_r <= base_addr_nxt;
      base_wdata_r <= base_wdata_nxt;
      sleep_r <= sleep_nxt;
      size_r <= size_nxt;
      uns_r <= uns_nxt;
      upd_r <= upd_nxt;
      elw_r <= elw_nxt;
    end
  end

  assign instr_ready_out = ready_r;
  assign illegal_out = illegal_r;
  assign mem_req_out = req_r;
  assign mem_we_out = we_r;
  assign mem_addr_out = addr_r;
  assign mem_be_out = be_r;
  assign mem_wdata_out = wdata_r;
  assign rd_we_out = rd_we_r;
  assign rd_addr_out = rd_addr_r;
  assign rd_wdata_out = rd_wdata_r;
  assign base_we_out = base_we_r;
  assign base_addr_out = base_addr_r;
  assign base_wdata_out = base_wdata_r;
  assign sleep_req_out = sleep_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_load_issue;
    req_r && !we_r && mem_gnt_in;
  endsequence
  sequence s_load_return;
    state_r == clsd_pkg::ST_WAIT && mem_rvalid_in;
  endsequence

  a_post_base_addr: assert property (accept && enabled && dec.upd |=>
    req_r && addr_r == $past(rs1_val_in) && base_wdata_r == $past(sum))
    else $error("post-increment access not at original base");
  a_rr_sum_addr: assert property (accept && enabled && !dec.upd |=> addr_r == $past(sum))
    else $error("register-register address is not base plus offset");
  a_illegal_flag: assert property (accept && !enabled |=> illegal_r && !req_r)
    else $error("disabled encoding was executed");
  a_req_hold: assert property (req_r && !mem_gnt_in |=> req_r && $stable(addr_r))
    else $error("request dropped before grant");
  a_load_wb: assert property (s_load_issue ##[1:16] s_load_return |=>
    base_we_r == (upd_r && base_addr_r != 5'h00) && state_r == clsd_pkg::ST_IDLE)
    else $error("load write-back missing");
  a_no_update: assert property (base_we_r |-> upd_r)
    else $error("base updated by a no-update form");
  a_zero_ext: assert property (rd_we_r && uns_r && size_r == clsd_pkg::SZ_BYTE |->
    rd_wdata_r[31:8] == 24'h000000)
    else $error("unsigned byte not zero-extended");
  a_sign_ext: assert property (rd_we_r && !uns_r && size_r == clsd_pkg::SZ_HALF |->
    rd_wdata_r[31:16] == {16{rd_wdata_r[15]}})
    else $error("signed half not sign-extended");
  a_word_raw: assert property (rd_we_r && size_r == clsd_pkg::SZ_WORD |->
    rd_wdata_r == $past(mem_rdata_in))
    else $error("word load altered");
  a_store_lanes: assert property (req_r && we_r |->
    $countones(be_r) == (size_r == clsd_pkg::SZ_BYTE ? 1 : size_r == clsd_pkg::SZ_HALF ? 2 : 4))
    else $error("store lanes wrong");
  a_elw_sleep: assert property (sleep_r |-> elw_r && rd_we_r == (rd_addr_r != 5'h00) && !base_we_r)
    else $error("sleep request without event load");
  a_cluster_gate: assert property (accept && dec.is_elw && !cluster_ext_enable_param |=> illegal_r)
    else $error("event load accepted while disabled");

endmodule // clsd_decoder

// File: testbench/clsd_mem_model.sv
// Behavioural data memory behind the load-store port
`timescale 1ns/100ps
module clsd_mem_model (
  // Clock, reset and wait states
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] lat_in,
  // Request side
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [3:0] mem_be_in,
  input wire logic [31:0] mem_wdata_in,
  // Answer side
  output logic mem_gnt_out,
  output logic mem_rvalid_out,
  output logic [31:0] mem_rdata_out
);
  logic [31:0] mem_r [16];
  logic [31:0] last_r;
  logic [3:0] cnt_r;
  logic [3:0] idx_r;
  logic pend_r;
  // Grant waits lat_in cycles, so a slow answer stretches the request
  assign mem_gnt_out = mem_req_in && !pend_r && cnt_r == lat_in;
  // Read data is not held: outside the valid cycle the bus shows the inverted word
  assign mem_rdata_out = mem_rvalid_out ? last_r : ~last_r;
  always_ff @(posedge clk_in) begin
    mem_rvalid_out <= 1'h0;
    if (!resetn_in) begin
      cnt_r <= 4'h0;
      pend_r <= 1'h0;
      last_r <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= 32'h81F2_7A93 + 32'(i);
      end
    end else if (mem_gnt_out) begin
      cnt_r <= 4'h0;
      pend_r <= !mem_we_in;
      idx_r <= mem_addr_in[5:2];
      for (int b = 0; b < 4; b++) begin
        if (mem_we_in && mem_be_in[b]) begin
          mem_r[mem_addr_in[5:2]][8*b +: 8] <= mem_wdata_in[8*b +: 8];
        end
      end
    end else if (pend_r && cnt_r == lat_in) begin
      mem_rvalid_out <= 1'h1;
      last_r <= mem_r[idx_r];
      pend_r <= 1'h0;
      cnt_r <= 4'h0;
    end else if (mem_req_in || pend_r) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // clsd_mem_model

// File: testbench/custom_load_store_decode_tb.sv
// Self-checking bench for the custom load/store decoder
`timescale 1ns/100ps
module custom_load_store_decode_tb;
  localparam logic [31:0] pre_base = 32'h81F2_7A93;
  localparam logic [2:0] ld3 [5] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2};
  localparam logic [6:0] ld7 [10] = '{7'h00, 7'h08, 7'h01, 7'h09, 7'h02, 7'h04, 7'h0C, 7'h05, 7'h0D, 7'h06};
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic instr_valid_in = 1'h0;
  logic off_valid = 1'h0;
  logic [31:0] instr_in = 32'h0000_0000;
  logic [31:0] rs1_val_in = 32'h0000_0000;
  logic [31:0] rs2_val_in = 32'h0000_0000;
  logic [31:0] rs3_val_in = 32'h0000_0000;
  logic [3:0] lat = 4'h0;
  logic instr_ready_out, illegal_out, mem_req_out, mem_we_out, mem_gnt_in, mem_rvalid_in;
  logic rd_we_out, base_we_out, sleep_req_out, rdy_off, ill_off, req_off;
  logic [3:0] mem_be_out;
  logic [4:0] rd_addr_out, base_addr_out;
  logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in, rd_wdata_out, base_wdata_out;
  logic g_we, g_rdw, g_bw, g_slp, g_illo, g_reqo;
  logic [3:0] g_be;
  logic [4:0] g_rda;
  logic [31:0] g_addr, g_wd, g_ng, g_rdd, g_bd;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  always #10 clk_in = ~clk_in;

  clsd_decoder i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .rs1_val_in(rs1_val_in), .rs2_val_in(rs2_val_in), .rs3_val_in(rs3_val_in),
    .instr_ready_out(instr_ready_out), .illegal_out(illegal_out), .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_be_out(mem_be_out),
    .mem_wdata_out(mem_wdata_out), .mem_gnt_in(mem_gnt_in), .mem_rvalid_in(mem_rvalid_in),
    .mem_rdata_in(mem_rdata_in), .rd_we_out(rd_we_out), .rd_addr_out(rd_addr_out),
    .rd_wdata_out(rd_wdata_out), .base_we_out(base_we_out), .base_addr_out(base_addr_out),
    .base_wdata_out(base_wdata_out), .sleep_req_out(sleep_req_out)
  );
  // Both extensions off: memory side tied, it must never be used
  clsd_decoder #(.custom_ext_enable_param(1'h0), .cluster_ext_enable_param(1'h0)) i_dut_off (
    .clk_in(clk_in), .resetn_in(resetn_in), .instr_valid_in(off_valid), .instr_in(instr_in),
    .rs1_val_in(rs1_val_in), .rs2_val_in(rs2_val_in), .rs3_val_in(rs3_val_in),
    .instr_ready_out(rdy_off), .illegal_out(ill_off), .mem_req_out(req_off), .mem_we_out(),
    .mem_addr_out(), .mem_be_out(), .mem_wdata_out(), .mem_gnt_in(1'h0), .mem_rvalid_in(1'h0),
    .mem_rdata_in(32'h0000_0000), .rd_we_out(), .rd_addr_out(), .rd_wdata_out(), .base_we_out(),
    .base_addr_out(), .base_wdata_out(), .sleep_req_out()
  );
  clsd_mem_model i_mem (
    .clk_in(clk_in), .resetn_in(resetn_in), .lat_in(lat), .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_be_in(mem_be_out),
    .mem_wdata_in(mem_wdata_out), .mem_gnt_out(mem_gnt_in), .mem_rvalid_out(mem_rvalid_in),
    .mem_rdata_out(mem_rdata_in)
  );

  function automatic logic [31:0] enc(input logic [6:0] f7, input logic [4:0] r2, r1,
    input logic [2:0] f3, input logic [4:0] rd, input logic [6:0] op);
    return {f7, r2, r1, f3, rd, op};
  endfunction

  function automatic logic [31:0] ldx(input logic [31:0] a, input logic [1:0] sz, input logic u);
    logic [31:0] s;
    s = (pre_base + {28'h0, a[5:2]}) >> (8 * a[1:0]);
    if (sz == 2'h0) return u ? {24'h0, s[7:0]} : {{24{s[7]}}, s[7:0]};
    if (sz == 2'h1) return u ? {16'h0, s[15:0]} : {{16{s[15]}}, s[15:0]};
    return s;
  endfunction

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Records what the unit hands out, sampled before the edge's own updates
  always @(posedge clk_in) begin
    cyc++;
    if (mem_req_out && mem_gnt_in) begin
      g_we = mem_we_out;
      g_addr = mem_addr_out;
      g_be = mem_be_out;
      g_wd = mem_wdata_out;
      g_ng = g_ng + 32'h1;
    end
    if (rd_we_out) {g_rdw, g_rda, g_rdd} = {1'h1, rd_addr_out, rd_wdata_out};
    if (base_we_out) {g_bw, g_bd} = {base_addr_out == 5'h05, base_wdata_out};
    if (sleep_req_out) g_slp = 1'h1;
    if (ill_off || illegal_out) g_illo = 1'h1;
    if (req_off) g_reqo = 1'h1;
    if (cyc == 2000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic wait_rdy(input logic off);
    for (int n = 0; n < 40 && (off ? rdy_off : instr_ready_out) !== 1'h1; n++) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  // Operands are scrambled after the accept edge: only the accepted values may count
  task automatic run_op(input logic off, input logic [31:0] ins, a, b, c);
    wait_rdy(off);
    {g_we, g_rdw, g_bw, g_slp, g_illo, g_reqo, g_be, g_rda, g_addr, g_wd, g_ng, g_rdd, g_bd} = '0;
    {instr_in, rs1_val_in, rs2_val_in, rs3_val_in} = {ins, a, b, c};
    {instr_valid_in, off_valid} = {!off, off};
    @(posedge clk_in);
    #1;
    {instr_valid_in, off_valid} = 2'h0;
    {rs1_val_in, rs2_val_in, rs3_val_in} = ~{a, b, c};
    wait_rdy(off);
    @(posedge clk_in);
    #1;
  endtask

  task automatic ck_ld(input logic [31:0] ad, rd, input logic upd, input logic [31:0] bd, input logic slp);
    chk(g_addr, ad);
    chk({g_ng[30:0], g_we}, 32'h2);
    chk({26'h0, g_rdw, g_rda}, 32'h27);
    chk(g_rdd, rd);
    chkf(g_bw, upd);
    if (upd) chk(g_bd, bd);
    chkf(g_slp, slp);
    chkf(g_illo, 1'h0);
  endtask

  task automatic t_reset;
    repeat (3) @(posedge clk_in);
    #1;
    chkf(mem_req_out | rd_we_out | base_we_out | illegal_out | instr_ready_out, 1'h0);
    resetn_in = 1'h1;
    // The unit is idle, so ready comes back at the first edge that sees reset released
    @(posedge clk_in);
    #1;
    chkf(instr_ready_out, 1'h1);
    @(posedge clk_in);
    #1;
    chkf(mem_req_out | rd_we_out | base_we_out | illegal_out | sleep_req_out, 1'h0);
  endtask

  task automatic t_imm_loads;
    logic [31:0] a;
    logic [11:0] im;
    for (int k = 0; k < 5; k++) begin
      a = 32'h0000_0100 + 32'(4 * k) + (ld3[k][1] ? 32'h0 : ld3[k][0] ? 32'h2 : 32'h3);
      im = 12'h800 + 12'(k);
      run_op(1'h0, enc(im[11:5], im[4:0], 5'h05, ld3[k], 5'h07, 7'h0B), a, 32'h0, 32'h0);
      ck_ld(a, ldx(a, ld3[k][1:0], ld3[k][2]), 1'h1, a + {{20{im[11]}}, im}, 1'h0);
    end
  endtask

  task automatic t_reg_loads;
    logic [31:0] a;
    logic [31:0] d;
    for (int k = 0; k < 10; k++) begin
      a = 32'h0000_0120 + 32'(4 * (k % 5)) + (ld7[k][1] ? 32'h0 : ld7[k][0] ? 32'h2 : 32'h3);
      d = 32'hFFFF_FFF0;
      run_op(1'h0, enc(ld7[k], 5'h09, 5'h05, 3'h3, 5'h07, 7'h2B), a, d, 32'h0);
      if (ld7[k][2]) ck_ld(a + d, ldx(a + d, ld7[k][1:0], ld7[k][3]), 1'h0, a, 1'h0);
      else ck_ld(a, ldx(a, ld7[k][1:0], ld7[k][3]), 1'h1, a + d, 1'h0);
    end
  endtask

  task automatic t_stores;
    logic [1:0] sz;
    logic [31:0] a, b, ad, m;
    logic [11:0] im;
    for (int k = 0; k < 9; k++) begin
      sz = 2'(k % 3);
      a = 32'h0000_0130 + (sz == 2'h2 ? 32'h0 : sz == 2'h1 ? 32'h2 : 32'h1);
      b = 32'hA5C3_96E1 + 32'(k);
      im = 12'h7F0 + 12'(k);
      if (k < 3) run_op(1'h0, enc(im[11:5], 5'h09, 5'h05, {1'h0, sz}, im[4:0], 7'h2B), a, b, 32'h8);
      else run_op(1'h0, enc({4'h2, k > 5, sz}, 5'h09, 5'h05, 3'h3, 5'h0B, 7'h2B), a, b, 32'h8);
      ad = k > 5 ? a + 32'h8 : a;
      m = (sz == 2'h0 ? 32'hFF : sz == 2'h1 ? 32'hFFFF : 32'hFFFF_FFFF) << (8 * ad[1:0]);
      chk({g_addr[31:1], g_we}, {ad[31:1], 1'h1});
      chk({28'h0, g_be}, {28'h0, m[24], m[16], m[8], m[0]});
      chk(g_wd & m, (b << (8 * ad[1:0])) & m);
      chkf(g_bw | g_rdw, k < 6);
      chkf(g_rdw | g_slp | g_illo, 1'h0);
      if (k < 6) chk(g_bd, a + (k < 3 ? {{20{im[11]}}, im} : 32'h8));
    end
  endtask

  task automatic t_event_load;
    run_op(1'h0, enc(7'h7F, 5'h18, 5'h05, 3'h3, 5'h07, 7'h0B), 32'h0000_002C, 32'h0, 32'h0);
    ck_ld(32'h0000_0024, ldx(32'h0000_0024, 2'h2, 1'h0), 1'h0, 32'h0, 1'h1);
  endtask

  task automatic t_disabled;
    logic [31:0] ins [7];
    ins = '{enc(7'h00, 5'h01, 5'h05, 3'h0, 5'h07, 7'h0B), enc(7'h00, 5'h09, 5'h05, 3'h3, 5'h07, 7'h2B),
      enc(7'h04, 5'h09, 5'h05, 3'h3, 5'h07, 7'h2B), enc(7'h01, 5'h09, 5'h05, 3'h2, 5'h03, 7'h2B),
      enc(7'h10, 5'h09, 5'h05, 3'h3, 5'h0B, 7'h2B), enc(7'h16, 5'h09, 5'h05, 3'h3, 5'h0B, 7'h2B),
      enc(7'h00, 5'h04, 5'h05, 3'h3, 5'h07, 7'h0B)};
    for (int k = 0; k < 7; k++) begin
      run_op(1'h1, ins[k], 32'h0000_0140, 32'h4, 32'h4);
      chk({30'h0, g_illo, g_reqo}, 32'h2);
    end
    // A loop-setup code shares the store opcode and must be ignored
    run_op(1'h0, enc(7'h00, 5'h00, 5'h05, 3'h4, 5'h00, 7'h2B), 32'h0000_0140, 32'h4, 32'h4);
    chk({g_ng[30:0], g_illo}, 32'h0);
  endtask

  initial begin
    t_reset();
    t_imm_loads();
    lat = 4'h3;
    t_reg_loads();
    lat = 4'h1;
    t_stores();
    t_event_load();
    t_disabled();
    close_out();
  end
endmodule // custom_load_store_decode_tb
